/* File: src/clock_source_select_defines.svh */
`ifndef CLOCK_SOURCE_SELECT_DEFINES_SVH
`define CLOCK_SOURCE_SELECT_DEFINES_SVH

// ******************************************************************
// Register offsets
// ******************************************************************
`define ADDR_PROCESSOR_CLOCK_CONFIG 8'h30
`define ADDR_TIMER_CLOCK_CONFIG     8'h31
`define ADDR_CLOCK_IO_CONFIG        8'h32
`define ADDR_PROCESSOR_SPEED        8'hE0

// ******************************************************************
// Reset values
// ******************************************************************
`define RST_TIMER_CLOCK_CONFIG      8'h8F
`define RST_CLOCK_IO_CONFIG         8'h00
`define RST_PROCESSOR_CLOCK_CONFIG  8'h00
`define RST_PROCESSOR_SPEED         3'h0

// ******************************************************************
// Field positions and write masks
// ******************************************************************
`define CAP_DIV_LSB                 6
`define CAP_SEL_LSB                 4
`define INT_DIV_LSB                 2
`define INT_SEL_LSB                 0
`define XSEL_BIT                    4
`define XEN_BIT                     3
`define FBYP_BIT                    2
`define OUTSEL_LSB                  0
`define CLOCK_IO_MASK               8'h1F
`define PROCESSOR_CLOCK_MASK        8'h01

// ******************************************************************
// Timing
// ******************************************************************
`define RECOVERY_SLOW_CYCLES        3
`define CLK_PERIOD_NS               4
`define CRYSTAL_STARTUP_MS          2
`define CRYSTAL_STARTUP_CYCLES      ((`CRYSTAL_STARTUP_MS * 1000000) / `CLK_PERIOD_NS)

`endif

/* File: src/clock_source_select_pkg.sv */
package clock_source_select_pkg;

  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0,
    SRC_EXTERNAL = 2'h1,
    SRC_LOW_POWER = 2'h2,
    SRC_ALT = 2'h3
  } clock_source_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic i;
    logic o;
    logic oe;
  } pad_t;

  typedef enum logic [1:0] {
    PWR_RUN = 2'h0,
    PWR_SLEEP = 2'h1,
    PWR_RECOVER = 2'h2
  } power_state_t;

endpackage

/* File: src/clock_divider_enable.sv */
`timescale 1ns/1ps
// Turns a source strobe into a divided strobe; a divisor of one passes every strobe.
module clock_divider_enable
  import clock_source_select_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire logic       src_tick,
  input  wire logic [7:0] divisor,
  output logic            div_tick
);

  logic [7:0] count_q;
  logic [7:0] count_d;
  logic       tick_q;
  logic       tick_d;

  always_comb begin
    count_d = count_q;
    tick_d  = 1'b0;
    if (src_tick) begin
      if (count_q + 8'h01 >= divisor) begin
        count_d = 8'h00;
        tick_d  = 1'b1;
      end else begin
        count_d = count_q + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= 8'h00;
      tick_q  <= 1'b0;
    end else if (clk_en) begin
      count_q <= count_d;
      tick_q  <= tick_d;
    end
  end

  assign div_tick = tick_q;

endmodule // clock_divider_enable

/* File: src/clock_source_select.sv */
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "clock_source_select_defines.svh"
// Summary of operation
// - Capture timer source: 00 internal, 01 external path, 10 low-power oscillator.
// - Crystal select set makes the crystal the external clock source.
// - Crystal enable takes clock input from crystal, disables both shared pin drivers.
// - Crystal disabled: clock input comes from pin 0 input path.
// - Filter bypass bit skips the transient filter when set.
// - Clock output select: internal, external path, low-power, processor clock.
// - Sleep entry forces processor source to internal and stops it.
// - Wake runs on internal oscillator, recovered within three slow cycles.
// - Reset returns every clock configuration register to default.
// - After reset internal clocking mode is active.
// - Power-on processor clock is internal oscillator divided by eight.
// - Processor source bit: 0 internal, 1 external path.
// - Processor speed resets to 000, meaning divide by eight.
//
// Clocks are modelled as one-cycle tick strobes in the core_clk domain, so every
// selection and division here is glitch-free by construction.
module clock_source_select
  import clock_source_select_pkg::*;
#(
  parameter logic [7:0] CAP_DIV_0 = 8'h01,
  parameter logic [7:0] CAP_DIV_1 = 8'h02,
  parameter logic [7:0] CAP_DIV_2 = 8'h04,
  parameter logic [7:0] CAP_DIV_3 = 8'h08,
  parameter logic [7:0] INT_DIV_2 = 8'h04,
  parameter logic [7:0] INT_DIV_3 = 8'h08
)(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire reg_req_t   reg_req,
  output logic [7:0]      reg_rdata,
  input  wire logic       internal_osc_tick,
  input  wire logic       low_power_osc_tick,
  input  wire logic       crystal_tick,
  input  wire logic       filtered_clock_input,
  input  wire logic       sleep_request,
  input  wire logic       wake_event,
  input  wire logic       port0_pin0_in,
  input  wire logic       port0_pin0_out,
  input  wire logic       port0_pin0_oe,
  input  wire logic       port0_pin1_out,
  input  wire logic       port0_pin1_oe,
  output pad_t            port0_pin0_pad,
  output pad_t            port0_pin1_pad,
  output logic            crystal_enable,
  output logic            clock_input_pin,
  output logic            clock_output_pin,
  output logic            processor_clock,
  output logic            capture_timer_clock,
  output logic            interval_timer_clock,
  output logic            internal_osc_run,
  output logic            processor_on_internal
);

  // ******************************************************************
  // Configuration registers
  // ******************************************************************
  logic [7:0] timer_clock_config_q;
  logic [7:0] timer_clock_config_d;
  logic [7:0] clock_io_config_q;
  logic [7:0] clock_io_config_d;
  logic [7:0] processor_usb_clock_config_q;
  logic [7:0] processor_usb_clock_config_d;
  logic [2:0] processor_speed_q;
  logic [2:0] processor_speed_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       sleep_force;

  always_comb begin
    timer_clock_config_d         = timer_clock_config_q;
    clock_io_config_d            = clock_io_config_q;
    processor_usb_clock_config_d = processor_usb_clock_config_q;
    processor_speed_d            = processor_speed_q;
    rdata_d                      = 8'h00;
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        `ADDR_TIMER_CLOCK_CONFIG:     timer_clock_config_d = reg_req.wdata;
        `ADDR_CLOCK_IO_CONFIG:        clock_io_config_d = reg_req.wdata & `CLOCK_IO_MASK;
        `ADDR_PROCESSOR_CLOCK_CONFIG: processor_usb_clock_config_d = reg_req.wdata & `PROCESSOR_CLOCK_MASK;
        `ADDR_PROCESSOR_SPEED:        processor_speed_d = reg_req.wdata[2:0];
        default: begin
        end
      endcase
    end
    // Hardware forcing on sleep wins over a write in the same cycle.
    if (sleep_force) begin
      processor_usb_clock_config_d[0] = 1'b0;
    end
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `ADDR_TIMER_CLOCK_CONFIG:     rdata_d = timer_clock_config_q;
        `ADDR_CLOCK_IO_CONFIG:        rdata_d = clock_io_config_q;
        `ADDR_PROCESSOR_CLOCK_CONFIG: rdata_d = processor_usb_clock_config_q;
        `ADDR_PROCESSOR_SPEED:        rdata_d = {5'h00, processor_speed_q};
        default:                      rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      timer_clock_config_q         <= `RST_TIMER_CLOCK_CONFIG;
      clock_io_config_q            <= `RST_CLOCK_IO_CONFIG;
      processor_usb_clock_config_q <= `RST_PROCESSOR_CLOCK_CONFIG;
      processor_speed_q            <= `RST_PROCESSOR_SPEED;
      rdata_q                      <= 8'h00;
    end else if (clk_en) begin
      timer_clock_config_q         <= timer_clock_config_d;
      clock_io_config_q            <= clock_io_config_d;
      processor_usb_clock_config_q <= processor_usb_clock_config_d;
      processor_speed_q            <= processor_speed_d;
      rdata_q                      <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ******************************************************************
  // Sleep and wake sequencing
  // ******************************************************************
  power_state_t power_q;
  power_state_t power_d;
  logic [1:0]   recover_q;
  logic [1:0]   recover_d;

  always_comb begin
    power_d     = power_q;
    recover_d   = recover_q;
    sleep_force = 1'b0;
    unique case (power_q)
      PWR_RUN: begin
        if (sleep_request) begin
          power_d     = PWR_SLEEP;
          sleep_force = 1'b1;
        end
      end
      PWR_SLEEP: begin
        sleep_force = 1'b1;
        if (wake_event) begin
          power_d   = PWR_RECOVER;
          recover_d = 2'h0;
        end
      end
      PWR_RECOVER: begin
        // The oscillator is back after three low-power cycles, never later.
        if (low_power_osc_tick) begin
          if (recover_q == 2'(`RECOVERY_SLOW_CYCLES - 1)) begin
            power_d = PWR_RUN;
          end else begin
            recover_d = recover_q + 2'h1;
          end
        end
      end
      default: power_d = PWR_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      power_q   <= PWR_RUN;
      recover_q <= 2'h0;
    end else if (clk_en) begin
      power_q   <= power_d;
      recover_q <= recover_d;
    end
  end

  assign internal_osc_run = (power_q == PWR_RUN);
  logic internal_tick;
  assign internal_tick = internal_osc_tick & internal_osc_run;

  // ******************************************************************
  // Clock input path and shared pads
  // ******************************************************************
  logic crystal_on;
  logic external_tick;
  logic pin_clock;
  assign crystal_on     = clock_io_config_q[`XEN_BIT];
  assign crystal_enable = crystal_on;
  // Without a crystal the raw pin feeds the clock input, filtered unless bypassed.
  assign pin_clock = clock_io_config_q[`FBYP_BIT] ? port0_pin0_in : filtered_clock_input;
  assign clock_input_pin = crystal_on ? crystal_tick : pin_clock;
  // The crystal drives the external path whenever enabled, whether selected or not; a selected
  // but stopped crystal yields no ticks rather than falling back silently to the pin.
  assign external_tick = clock_io_config_q[`XSEL_BIT] ? (crystal_on & crystal_tick) : clock_input_pin;

  always_comb begin
    port0_pin0_pad.i  = port0_pin0_in;
    port0_pin0_pad.o  = port0_pin0_out;
    port0_pin0_pad.oe = port0_pin0_oe & ~crystal_on;
    port0_pin1_pad.i  = 1'b0;
    port0_pin1_pad.o  = port0_pin1_out;
    port0_pin1_pad.oe = port0_pin1_oe & ~crystal_on;
  end

  // ******************************************************************
  // Source selection
  // ******************************************************************
  function automatic logic pick(input logic [1:0] sel, input logic a, input logic b,
                                input logic c, input logic d);
    unique case (sel)
      2'h0:    pick = a;
      2'h1:    pick = b;
      2'h2:    pick = c;
      default: pick = d;
    endcase
  endfunction

  logic processor_src_tick;
  logic cap_src_tick;
  logic int_src_tick;
  logic cap_tick;
  logic int_tick;
  logic proc_tick;
  logic [7:0] cap_div;
  logic [7:0] int_div;
  logic [7:0] proc_div;

  assign processor_on_internal = ~processor_usb_clock_config_q[0];
  assign processor_src_tick = processor_usb_clock_config_q[0] ? external_tick : internal_tick;
  // Code 11 of the capture source is reserved here and yields no clock.
  assign cap_src_tick = pick(timer_clock_config_q[`CAP_SEL_LSB +: 2], internal_tick, external_tick,
                             low_power_osc_tick, 1'b0);
  assign int_src_tick = pick(timer_clock_config_q[`INT_SEL_LSB +: 2], internal_tick, external_tick,
                             low_power_osc_tick, cap_tick);

  always_comb begin
    unique case (timer_clock_config_q[`CAP_DIV_LSB +: 2])
      2'h0:    cap_div = CAP_DIV_0;
      2'h1:    cap_div = CAP_DIV_1;
      2'h2:    cap_div = CAP_DIV_2;
      default: cap_div = CAP_DIV_3;
    endcase
    unique case (timer_clock_config_q[`INT_DIV_LSB +: 2])
      2'h0:    int_div = 8'h01;
      2'h1:    int_div = 8'h02;
      2'h2:    int_div = INT_DIV_2;
      default: int_div = INT_DIV_3;
    endcase
    // Codes 110 and 111 are reserved and both divide by 128, slower than any other code.
    case (processor_speed_q)
      3'h0:    proc_div = 8'h08;
      3'h1:    proc_div = 8'h04;
      3'h2:    proc_div = 8'h02;
      3'h3:    proc_div = 8'h01;
      3'h4:    proc_div = 8'h10;
      3'h5:    proc_div = 8'h20;
      default: proc_div = 8'h80;
    endcase
  end

  // ******************************************************************
  // Dividers
  // ******************************************************************
  logic [2:0] div_src;
  logic [2:0] div_out;
  logic [7:0] div_val [3];
  assign div_src    = {processor_src_tick, int_src_tick, cap_src_tick};
  assign div_val[0] = cap_div;
  assign div_val[1] = int_div;
  assign div_val[2] = proc_div;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_div
      clock_divider_enable u_div (
        .core_clk (core_clk),
        .nrst     (nrst),
        .clk_en   (clk_en),
        .src_tick (div_src[g]),
        .divisor  (div_val[g]),
        .div_tick (div_out[g])
      );
    end
  endgenerate

  assign cap_tick  = div_out[0];
  assign int_tick  = div_out[1];
  assign proc_tick = div_out[2];

  assign capture_timer_clock  = cap_tick;
  assign interval_timer_clock = int_tick;
  assign processor_clock      = proc_tick;
  assign clock_output_pin = pick(clock_io_config_q[`OUTSEL_LSB +: 2], internal_tick, external_tick,
                                 low_power_osc_tick, proc_tick);

endmodule // clock_source_select

/* File: verif/clock_source_select_monitor.sv */
`timescale 1ns/1ps
`include "clock_source_select_defines.svh"
module clock_source_select_monitor
  import clock_source_select_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       clk_en,
  input wire reg_req_t   reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic       low_power_osc_tick,
  input wire logic       crystal_tick,
  input wire logic       filtered_clock_input,
  input wire logic       sleep_request,
  input wire logic       wake_event,
  input wire logic       port0_pin0_in,
  input wire logic       port0_pin0_out,
  input wire logic       port0_pin0_oe,
  input wire pad_t       port0_pin0_pad,
  input wire pad_t       port0_pin1_pad,
  input wire logic       crystal_enable,
  input wire logic       clock_input_pin,
  input wire logic       internal_osc_run,
  input wire logic       processor_on_internal
);
  // ********
  // Wake recovery tracking
  // ********
  logic       wake_seen_q;
  logic       wake_seen_d;
  logic [2:0] slow_cnt_q;
  logic [2:0] slow_cnt_d;
  logic       bypass_q;
  logic       bypass_d;

  // Slow ticks count only once the wake has been taken, as the recovery wait does.
  always_comb begin
    wake_seen_d = wake_seen_q;
    slow_cnt_d  = slow_cnt_q;
    bypass_d    = bypass_q;
    // Mirror of the filter bypass bit, so the pin path can be checked exactly.
    if (clk_en && reg_req.wr && reg_req.addr == `ADDR_CLOCK_IO_CONFIG) bypass_d = reg_req.wdata[`FBYP_BIT];
    if (internal_osc_run) begin
      wake_seen_d = 1'b0;
      slow_cnt_d  = 3'h0;
    end else if (clk_en) begin
      if (wake_seen_q && low_power_osc_tick) slow_cnt_d = slow_cnt_q + 3'h1;
      if (wake_event) wake_seen_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wake_seen_q <= 1'b0;
      slow_cnt_q  <= 3'h0;
      bypass_q    <= 1'b0;
    end else begin
      wake_seen_q <= wake_seen_d;
      slow_cnt_q  <= slow_cnt_d;
      bypass_q    <= bypass_d;
    end
  end

  default clocking mon_cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  AST_PAD_OE_OFF: assert property (crystal_enable |-> !port0_pin0_pad.oe && !port0_pin1_pad.oe)
    else $error("shared pad driver on while crystal enabled");
  AST_CIN_CRYSTAL: assert property (crystal_enable |-> clock_input_pin == crystal_tick)
    else $error("clock input not from crystal");
  AST_CIN_PIN: assert property (!crystal_enable |-> clock_input_pin ==
    (bypass_q ? port0_pin0_in : filtered_clock_input)) else $error("clock input not from pin path");
  AST_PAD_PASS: assert property (!crystal_enable |-> port0_pin0_pad.oe == port0_pin0_oe &&
    port0_pin0_pad.o == port0_pin0_out) else $error("pin driver blocked with crystal off");
  AST_IO_MASK: assert property (reg_req.rd && clk_en && reg_req.addr == `ADDR_CLOCK_IO_CONFIG
    |=> reg_rdata[7:5] == 3'h0) else $error("reserved io bits read nonzero");
  AST_UNMAPPED_ZERO: assert property (reg_req.rd && clk_en && !(reg_req.addr inside {8'h30, 8'h31, 8'h32,
    8'hE0}) |=> reg_rdata == 8'h00) else $error("unmapped read nonzero");
  AST_SLEEP_FORCE: assert property (clk_en && sleep_request && internal_osc_run |=>
    !internal_osc_run && processor_on_internal) else $error("sleep entry did not force internal");
  AST_STAY_INTERNAL: assert property (!internal_osc_run |-> processor_on_internal)
    else $error("processor off internal while oscillator stopped");
  AST_RECOVER_BOUND: assert property (slow_cnt_q == 3'h3 |-> internal_osc_run)
    else $error("recovery exceeded three slow cycles");

  cover property (crystal_enable && crystal_tick);
  cover property (clk_en && sleep_request && internal_osc_run);
  cover property (slow_cnt_q == 3'h3);
endmodule // clock_source_select_monitor

/* File: verif/clock_pin_source_model.sv */
`timescale 1ns/1ps
// ********
// Crystal and pin clock source
// ********
module clock_pin_source_model #(
  parameter int STARTUP = 40,
  parameter int XDIV    = 3,
  parameter int PDIV    = 5
)(
  input  wire logic core_clk,
  input  wire logic crystal_enable,
  output logic      crystal_tick,
  output logic      pin_raw,
  output logic      pin_filtered
);
  int xcnt = 0;
  int pcnt = 0;

  initial {crystal_tick, pin_raw, pin_filtered} = 3'h0;

  // The filter is modelled as one cycle of delay so the two pin paths differ.
  always @(posedge core_clk) begin
    pcnt <= (pcnt + 1) % PDIV;
    pin_raw <= (pcnt == 0);
    pin_filtered <= pin_raw;
    xcnt <= crystal_enable ? xcnt + 1 : 0;
    crystal_tick <= crystal_enable && xcnt >= STARTUP && (xcnt % XDIV == 0);
  end
endmodule // clock_pin_source_model

/* File: verif/clock_source_select_tb.sv */
`timescale 1ns/1ps
`include "clock_source_select_defines.svh"
module clock_source_select_tb;
  import clock_source_select_pkg::*;
  localparam int STARTUP = 40;
  // ********
  // Bench
  // ********
  reg_req_t   reg_req;
  pad_t       port0_pin0_pad, port0_pin1_pad;
  logic [7:0] reg_rdata, d;
  logic [3:0] tcnt = 4'h0;
  logic core_clk, nrst, clk_en, internal_osc_tick, low_power_osc_tick, crystal_tick, filtered_clock_input;
  logic sleep_request, wake_event, port0_pin0_in, port0_pin0_out, port0_pin0_oe, port0_pin1_out, port0_pin1_oe;
  logic crystal_enable, clock_input_pin, clock_output_pin, processor_clock, capture_timer_clock;
  logic interval_timer_clock, internal_osc_run, processor_on_internal, prev, prevc;
  int   n_mismatch, num_checks, proc_cnt, itv_cnt, c0, slow, n;

  clock_source_select dut_u (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .internal_osc_tick(internal_osc_tick), .low_power_osc_tick(low_power_osc_tick),
    .crystal_tick(crystal_tick), .filtered_clock_input(filtered_clock_input), .sleep_request(sleep_request),
    .wake_event(wake_event), .port0_pin0_in(port0_pin0_in), .port0_pin0_out(port0_pin0_out),
    .port0_pin0_oe(port0_pin0_oe), .port0_pin1_out(port0_pin1_out), .port0_pin1_oe(port0_pin1_oe),
    .port0_pin0_pad(port0_pin0_pad), .port0_pin1_pad(port0_pin1_pad), .crystal_enable(crystal_enable),
    .clock_input_pin(clock_input_pin), .clock_output_pin(clock_output_pin), .processor_clock(processor_clock),
    .capture_timer_clock(capture_timer_clock), .interval_timer_clock(interval_timer_clock),
    .internal_osc_run(internal_osc_run), .processor_on_internal(processor_on_internal));

  clock_pin_source_model #(.STARTUP(STARTUP)) src_u (.core_clk(core_clk), .crystal_enable(crystal_enable),
    .crystal_tick(crystal_tick), .pin_raw(port0_pin0_in), .pin_filtered(filtered_clock_input));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // The internal oscillator stops outside run, as the real one does.
  always @(posedge core_clk) begin
    tcnt <= tcnt + 4'h1;
    internal_osc_tick <= internal_osc_run & tcnt[0];
    low_power_osc_tick <= (tcnt == 4'hF);
    {port0_pin0_out, port0_pin0_oe, port0_pin1_out, port0_pin1_oe} <= 4'($urandom);
    proc_cnt <= proc_cnt + int'(processor_clock);
    itv_cnt <= itv_cnt + int'(interval_timer_clock);
  end

  function automatic logic out_src(input logic [1:0] code);
    case (code)
      2'h0: return internal_osc_tick;
      2'h1: return clock_input_pin;
      2'h2: return low_power_osc_tick;
      default: return processor_clock;
    endcase
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    void'($urandom(40));
    {nrst, reg_req} = '0;
    clk_en = 1'b1;
    {sleep_request, wake_event} = 2'h0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    rd_chk(`ADDR_PROCESSOR_CLOCK_CONFIG, `RST_PROCESSOR_CLOCK_CONFIG);
    rd_chk(`ADDR_TIMER_CLOCK_CONFIG, `RST_TIMER_CLOCK_CONFIG);
    rd_chk(`ADDR_CLOCK_IO_CONFIG, `RST_CLOCK_IO_CONFIG);
    rd_chk(`ADDR_PROCESSOR_SPEED, 8'h00);
    @(posedge core_clk) clk_en <= 1'b0;
    wr(`ADDR_CLOCK_IO_CONFIG, 8'h1F);
    clk_en <= 1'b1;
    rd_chk(`ADDR_CLOCK_IO_CONFIG, `RST_CLOCK_IO_CONFIG);
    c0 = proc_cnt;
    repeat (160) @(posedge core_clk);
    chk(((proc_cnt - c0) inside {[9:11]}), 8'h01);
    $display("test reset defaults done");
    wr(`ADDR_CLOCK_IO_CONFIG, 8'hE7);
    rd_chk(`ADDR_CLOCK_IO_CONFIG, 8'h07);
    wr(`ADDR_PROCESSOR_CLOCK_CONFIG, 8'hFE);
    rd_chk(`ADDR_PROCESSOR_CLOCK_CONFIG, 8'h00);
    wr(`ADDR_PROCESSOR_SPEED, 8'hFB);
    rd_chk(`ADDR_PROCESSOR_SPEED, 8'h03);
    wr(8'h55, 8'hFF);
    rd_chk(8'h55, 8'h00);
    repeat (4) begin
      d = 8'($urandom);
      wr(`ADDR_TIMER_CLOCK_CONFIG, d);
      rd_chk(`ADDR_TIMER_CLOCK_CONFIG, d);
    end
    wr(`ADDR_PROCESSOR_SPEED, 8'h00);
    $display("test register access done");
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_CLOCK_IO_CONFIG, 8'(c));
      repeat (40) @(posedge core_clk) #1 chk(clock_output_pin, out_src(2'(c)));
    end
    for (int c = 0; c < 3; c++) begin
      wr(`ADDR_TIMER_CLOCK_CONFIG, {2'b00, 2'(c), 4'b0011});
      repeat (6) @(posedge core_clk);
      #1 {prev, prevc} = {out_src(2'(c)), capture_timer_clock};
      repeat (40) begin
        @(posedge core_clk) #1 chk(capture_timer_clock, prev);
        chk(interval_timer_clock, prevc);
        {prev, prevc} = {out_src(2'(c)), capture_timer_clock};
      end
    end
    wr(`ADDR_TIMER_CLOCK_CONFIG, 8'h04);
    c0 = itv_cnt;
    repeat (64) @(posedge core_clk);
    chk(((itv_cnt - c0) inside {[15:17]}), 8'h01);
    $display("test clock selection done");
    wr(`ADDR_CLOCK_IO_CONFIG, 8'h08);
    repeat (STARTUP + 10) @(posedge core_clk);
    wr(`ADDR_CLOCK_IO_CONFIG, 8'h19);
    wr(`ADDR_PROCESSOR_CLOCK_CONFIG, 8'h01);
    #1 chk(processor_on_internal, 8'h00);
    repeat (30) begin
      @(posedge core_clk) #1 chk(clock_input_pin, crystal_tick);
      chk(clock_output_pin, crystal_tick);
      chk({crystal_enable, port0_pin0_pad.oe, port0_pin1_pad.oe}, 8'h04);
    end
    @(posedge core_clk) sleep_request <= 1'b1;
    @(posedge core_clk) sleep_request <= 1'b0;
    #1 chk(internal_osc_run, 8'h00);
    rd_chk(`ADDR_PROCESSOR_CLOCK_CONFIG, 8'h00);
    repeat (20) @(posedge core_clk);
    @(posedge core_clk) wake_event <= 1'b1;
    @(posedge core_clk) wake_event <= 1'b0;
    #1 {slow, n} = '0;
    while (!internal_osc_run && n < 200) begin
      slow += int'(low_power_osc_tick);
      @(posedge core_clk) #1 n++;
    end
    chk(8'(slow), 8'h03);
    chk(processor_on_internal, 8'h01);
    wr(`ADDR_CLOCK_IO_CONFIG, 8'h08);
    wr(`ADDR_CLOCK_IO_CONFIG, 8'h00);
    wr(`ADDR_CLOCK_IO_CONFIG, 8'h08);
    repeat (STARTUP + 10) @(posedge core_clk);
    wr(`ADDR_CLOCK_IO_CONFIG, 8'h19);
    wr(`ADDR_PROCESSOR_CLOCK_CONFIG, 8'h01);
    #1 chk(processor_on_internal, 8'h00);
    wr(`ADDR_PROCESSOR_CLOCK_CONFIG, 8'h00);
    wr(`ADDR_CLOCK_IO_CONFIG, 8'h08);
    wr(`ADDR_CLOCK_IO_CONFIG, 8'h04);
    $display("test crystal and sleep done");
    repeat (20) @(posedge core_clk) #1 chk(clock_input_pin, port0_pin0_in);
    wr(`ADDR_CLOCK_IO_CONFIG, 8'h00);
    repeat (20) begin
      @(posedge core_clk) #1 chk(clock_input_pin, filtered_clock_input);
      chk({port0_pin0_pad, port0_pin1_pad}, {port0_pin0_in, port0_pin0_out, port0_pin0_oe, 1'b0,
        port0_pin1_out, port0_pin1_oe});
    end
    wr(`ADDR_TIMER_CLOCK_CONFIG, 8'h00);
    wr(`ADDR_CLOCK_IO_CONFIG, 8'h03);
    @(posedge core_clk) nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rd_chk(`ADDR_TIMER_CLOCK_CONFIG, `RST_TIMER_CLOCK_CONFIG);
    rd_chk(`ADDR_CLOCK_IO_CONFIG, `RST_CLOCK_IO_CONFIG);
    $display("test bypass and reset done");
    complete_run();
  end
endmodule // clock_source_select_tb

bind clock_source_select clock_source_select_monitor mon_u (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .low_power_osc_tick(low_power_osc_tick), .crystal_tick(crystal_tick),
  .filtered_clock_input(filtered_clock_input), .sleep_request(sleep_request), .wake_event(wake_event),
  .port0_pin0_in(port0_pin0_in), .port0_pin0_out(port0_pin0_out), .port0_pin0_oe(port0_pin0_oe),
  .port0_pin0_pad(port0_pin0_pad), .port0_pin1_pad(port0_pin1_pad), .crystal_enable(crystal_enable),
  .clock_input_pin(clock_input_pin), .internal_osc_run(internal_osc_run),
  .processor_on_internal(processor_on_internal));
